// ---- core/wat_pkg.sv ----
// Constants shared by the wake-up alarm timer.
// Assumes a 125 MHz system clock and a 32.768 kHz crystal clock pin.
package wat_pkg;

    // ----------------------------------------------------------------
    // Counter and compare
    // ----------------------------------------------------------------
    localparam int          CNT_W     = 24;
    localparam logic [23:0] CMP_RST   = 24'hff_ffff;
    localparam logic [23:0] CNT_RST   = 24'h00_0000;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int SYS_CLK_MHZ  = 125;
    localparam int XTAL_HZ      = 32768;
    localparam int PRESCALE_DIV = XTAL_HZ;
    localparam int DEB_TIME_US  = 1000;
    localparam int DEB_CYCLES   = DEB_TIME_US * SYS_CLK_MHZ;

    // ----------------------------------------------------------------
    // Serial link framing
    // ----------------------------------------------------------------
    localparam logic [6:0] SLV_ADDR   = 7'h3a;  // Arbitrary value
    localparam logic [5:0] SLOT_BITS  = 6'h09;
    localparam logic [5:0] BYTE_LAST  = 6'h07;
    localparam logic [5:0] ACK_SLOT   = 6'h08;
    localparam logic [5:0] LAST_BIT   = 6'h23;
    localparam logic [5:0] FRAME_END  = 6'h24;
    localparam logic [5:0] RESYNC_IDX = 6'h02;

endpackage : wat_pkg

// ---- core/wat_timer.sv ----
// Wake-up alarm timer: seconds counter, compare value, alarm output,
// debounced restart input and a write-only two-wire slave.
// Assumes sys_clk_in at 125 MHz and serial clock from the host.
`timescale 1ns/1ps
module wat_timer #(
    parameter int PRESCALE        = wat_pkg::PRESCALE_DIV,
    parameter int DEBOUNCE_CYCLES = wat_pkg::DEB_CYCLES
) (
    // System clock and reset
    input  wire logic                     sys_clk_in,
    input  wire logic                     reset_n_in,
    // Crystal and restart pins
    input  wire logic                     xtal_clk_in,
    input  wire logic                     restart_n_in,
    // Serial link
    input  wire logic                     scl_clk_in,
    input  wire logic                     sda_in,
    output logic                          sda_out,
    output logic                          sda_oe_out,
    // Alarm
    output logic                          alarm_out
);
    import wat_pkg::*;

    localparam int PRE_W = $clog2(PRESCALE);
    localparam int DEB_W = $clog2(DEBOUNCE_CYCLES + 1);

    // ----------------------------------------------------------------
    // Link-side state, clocked by the host serial clock
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              tog_s1;
        logic              tog_s2;
        logic              tog_seen;
        logic [5:0]        bit_cnt;
        logic [7:0]        shift;
        logic              addr_ok;
        logic [CNT_W-1:0]  data;
        logic [CNT_W-1:0]  val;
        logic              wr_tog;
        logic              ack_req;
    } wat_lnk_t;

    // ----------------------------------------------------------------
    // System-side state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              xt_s1;
        logic              xt_s2;
        logic              xt_d;
        logic              rs_s1;
        logic              rs_s2;
        logic              deb_lvl;
        logic [DEB_W-1:0]  deb_cnt;
        logic              scl_s1;
        logic              scl_s2;
        logic              scl_d;
        logic              sda_s1;
        logic              sda_s2;
        logic              sda_d;
        logic              start_tog;
        logic              wr_s1;
        logic              wr_s2;
        logic              wr_d;
        logic              ak_s1;
        logic              ak_s2;
        logic              sda_oe;
        logic [CNT_W-1:0]  cmp;
        logic [CNT_W-1:0]  count;
        logic [PRE_W-1:0]  pre;
        logic              alarm;
    } wat_sys_t;

    wat_lnk_t lnk_ff;
    wat_lnk_t nxt_lnk;
    wat_sys_t sys_ff;
    wat_sys_t nxt_sys;

    logic tick;
    logic sec;
    logic wr_evt;
    logic rise;
    logic running;

    // ----------------------------------------------------------------
    // Link receiver
    // ----------------------------------------------------------------
    always_comb begin : lnk_next
        logic [5:0] idx;
        logic [5:0] slot;
        logic [7:0] byte_v;
        idx          = '0;
        slot         = '0;
        byte_v       = '0;
        nxt_lnk      = lnk_ff;
        nxt_lnk.tog_s1 = sys_ff.start_tog;
        nxt_lnk.tog_s2 = lnk_ff.tog_s1;
        nxt_lnk.tog_seen = lnk_ff.tog_s2;
        // Start seen two edges late: this edge carries bit 2
        idx = (lnk_ff.tog_s2 != lnk_ff.tog_seen) ? RESYNC_IDX
                                                 : lnk_ff.bit_cnt;
        nxt_lnk.bit_cnt = (idx < FRAME_END) ? idx + 6'h01 : FRAME_END;
        slot   = idx % SLOT_BITS;
        byte_v = {lnk_ff.shift[6:0], sda_in};
        if (idx >= FRAME_END || slot != ACK_SLOT) begin
            nxt_lnk.shift = byte_v;
        end
        if (idx < FRAME_END && slot == BYTE_LAST) begin
            if (idx == BYTE_LAST) begin
                nxt_lnk.addr_ok = (byte_v == {SLV_ADDR, 1'b0});
                nxt_lnk.ack_req = (byte_v == {SLV_ADDR, 1'b0});
            end else begin
                // High byte first
                nxt_lnk.data    = {lnk_ff.data[15:0], byte_v};
                nxt_lnk.ack_req = lnk_ff.addr_ok;
            end
        end
        if (idx < FRAME_END && slot == ACK_SLOT) begin
            nxt_lnk.ack_req = 1'b0;
            if (idx == LAST_BIT && lnk_ff.addr_ok) begin
                nxt_lnk.val    = lnk_ff.data;
                nxt_lnk.wr_tog = ~lnk_ff.wr_tog;
            end
        end
    end

    // Serial clock stands still between frames, so reset acts at once
    always_ff @(posedge scl_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lnk_ff <= '{bit_cnt: FRAME_END, data: CNT_RST, val: CNT_RST,
                        default: '0};
        end else begin
            lnk_ff <= nxt_lnk;
        end
    end

    // ----------------------------------------------------------------
    // Timer, debounce and pin handling
    // ----------------------------------------------------------------
    assign tick    = sys_ff.xt_s2 & ~sys_ff.xt_d;
    assign sec     = tick && sys_ff.pre == PRE_W'(PRESCALE - 1);
    assign wr_evt  = sys_ff.wr_s2 != sys_ff.wr_d;
    assign running = sys_ff.deb_lvl & ~sys_ff.alarm;
    assign rise    = ~sys_ff.deb_lvl & sys_ff.rs_s2 &
                     (sys_ff.deb_cnt == DEB_W'(DEBOUNCE_CYCLES - 1));

    always_comb begin : sys_next
        nxt_sys        = sys_ff;
        nxt_sys.xt_s1  = xtal_clk_in;
        nxt_sys.xt_s2  = sys_ff.xt_s1;
        nxt_sys.xt_d   = sys_ff.xt_s2;
        nxt_sys.rs_s1  = restart_n_in;
        nxt_sys.rs_s2  = sys_ff.rs_s1;
        nxt_sys.scl_s1 = scl_clk_in;
        nxt_sys.scl_s2 = sys_ff.scl_s1;
        nxt_sys.scl_d  = sys_ff.scl_s2;
        nxt_sys.sda_s1 = sda_in;
        nxt_sys.sda_s2 = sys_ff.sda_s1;
        nxt_sys.sda_d  = sys_ff.sda_s2;
        nxt_sys.wr_s1  = lnk_ff.wr_tog;
        nxt_sys.wr_s2  = sys_ff.wr_s1;
        nxt_sys.wr_d   = sys_ff.wr_s2;
        nxt_sys.ak_s1  = lnk_ff.ack_req;
        nxt_sys.ak_s2  = sys_ff.ak_s1;
        // Start: data falls while clock high
        if (sys_ff.scl_s2 && sys_ff.scl_d && sys_ff.sda_d &&
            !sys_ff.sda_s2) begin
            nxt_sys.start_tog = ~sys_ff.start_tog;
        end
        // Level must hold steady for the full window
        if (sys_ff.rs_s2 != sys_ff.deb_lvl) begin
            nxt_sys.deb_cnt = sys_ff.deb_cnt + DEB_W'(1);
            if (sys_ff.deb_cnt == DEB_W'(DEBOUNCE_CYCLES - 1)) begin
                nxt_sys.deb_lvl = sys_ff.rs_s2;
                nxt_sys.deb_cnt = '0;
            end
        end else begin
            nxt_sys.deb_cnt = '0;
        end
        // Release only while the clock is low
        if (!sys_ff.scl_s2) begin
            nxt_sys.sda_oe = sys_ff.ak_s2;
        end
        if (!sys_ff.deb_lvl) begin
            nxt_sys.count = CNT_RST;
            nxt_sys.pre   = '0;
        end else if (!sys_ff.alarm) begin
            if (tick) begin
                nxt_sys.pre = sec ? '0 : sys_ff.pre + PRE_W'(1);
            end
            if (sec) begin
                nxt_sys.count = sys_ff.count + 24'h00_0001;
            end
        end
        if (wr_evt) begin
            nxt_sys.cmp = lnk_ff.val;
            if (running) begin
                nxt_sys.count = CNT_RST;
                nxt_sys.pre   = '0;
            end
        end else if (running && sys_ff.count == sys_ff.cmp) begin
            nxt_sys.alarm = 1'b1;
        end
        if (rise) begin
            nxt_sys.alarm = 1'b0;
            nxt_sys.count = CNT_RST;
            nxt_sys.pre   = '0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            // Pin treated as pulled high until sampled
            sys_ff <= '{rs_s1: 1'b1, rs_s2: 1'b1, deb_lvl: 1'b1,
                        scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
                        sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
                        cmp: CMP_RST, count: CNT_RST, default: '0};
        end else begin
            sys_ff <= nxt_sys;
        end
    end

    assign sda_out    = 1'b0;
    assign sda_oe_out = sys_ff.sda_oe;
    assign alarm_out  = sys_ff.alarm;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_count_held_low: assert property (
        !sys_ff.deb_lvl && !wr_evt |=> sys_ff.count == CNT_RST)
        else $error("Counter not cleared while restart low");
    a_alarm_freezes: assert property (
        sys_ff.alarm && sys_ff.deb_lvl |=> $stable(sys_ff.count))
        else $error("Counter moved while alarm high");
    a_match_alarm: assert property (
        running && !wr_evt && sys_ff.count == sys_ff.cmp
        |=> sys_ff.alarm)
        else $error("Match did not raise alarm");
    a_rise_restart: assert property (
        rise |=> !sys_ff.alarm && sys_ff.count == CNT_RST
        ##1 !sys_ff.alarm)
        else $error("Restart did not clear alarm and counter");
    a_write_restart: assert property (
        wr_evt && running
        |=> sys_ff.count == CNT_RST && sys_ff.cmp == $past(lnk_ff.val))
        else $error("Compare write did not restart counter");
    a_count_step: assert property (
        sys_ff.deb_lvl && !wr_evt && !rise
        |=> sys_ff.count == $past(sys_ff.count) ||
            sys_ff.count == $past(sys_ff.count) + 24'h00_0001)
        else $error("Counter moved by other than one");
    a_second_only: assert property (
        !sec && !wr_evt && !rise && sys_ff.deb_lvl
        |=> $stable(sys_ff.count))
        else $error("Counter moved without a second tick");
    a_prescale_wrap: assert property (
        sec && running && !wr_evt |=> sys_ff.pre == '0)
        else $error("Prescaler did not wrap at second");
    a_debounce_hold: assert property (
        $changed(sys_ff.deb_lvl)
        |-> $past(sys_ff.deb_cnt) == DEB_W'(DEBOUNCE_CYCLES - 1))
        else $error("Restart level changed before debounce");
    a_oe_clock_low: assert property (
        $changed(sys_ff.sda_oe) |-> !$past(sys_ff.scl_s2))
        else $error("Data line changed while clock high");

endmodule : wat_timer

// ---- dv/wat_i2c_host.sv ----
// Two-wire host model that writes frames to the wake-up alarm timer.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module wat_i2c_host (
    // Serial link
    output logic       scl_out,
    output logic       sda_low_out,
    input  wire logic  sda_in
);
    // ----------------------------------------------------------------
    // Idle bus: clock stands high, data released
    // ----------------------------------------------------------------
    initial begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end

    // One clock period; data changes mid low phase, sampled before fall
    task automatic send_bit(input logic b, output logic seen);
        #20 sda_low_out = ~b;
        #20 scl_out = 1'b1;
        #40 seen = sda_in;
        scl_out = 1'b0;
    endtask : send_bit

    // Bytes go out from the top of the word, high data byte first
    task automatic write_frame(input logic [31:0] bytes, input int n,
                               output logic [3:0] acks);
        logic s;
        acks = 4'hf;
        // Keep link edges off the system clock edges
        #3;
        sda_low_out = 1'b1;
        #40 scl_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            for (int j = 7; j >= 0; j--) begin
                send_bit(bytes[8 * (3 - i) + j], s);
            end
            send_bit(1'b1, s);
            acks[i] = s;
        end
        #20 sda_low_out = 1'b1;
        #20 scl_out = 1'b1;
        #20 sda_low_out = 1'b0;
        #40;
    endtask : write_frame
endmodule : wat_i2c_host

// ---- dv/test_wakeup_alarm_timer.sv ----
// Self-checking bench for the wake-up alarm timer.
// Assumes wat_pkg, wat_timer and the host model are compiled first.
`timescale 1ns/1ps
module test_wakeup_alarm_timer;
    import wat_pkg::*;
    localparam int PRE = 4;
    localparam int XH  = 50;
    logic        sys_clk_in = 1'b0;
    logic        reset_n_in;
    logic        xtal_clk   = 1'b0;
    logic        rst_en     = 1'b0;
    logic        rst_val    = 1'b1;
    logic        host_low;
    logic        scl;
    logic        sda_out;
    logic        sda_oe;
    logic        alarm;
    logic [3:0]  acks;
    logic [23:0] c1;
    int          fails = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          xc = 0;
    int          seed = 6579;
    wire         sda_w = (host_low | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
    wire         restart_w = rst_en ? rst_val : 1'b1;

    initial forever #4 sys_clk_in = ~sys_clk_in;

    wat_timer #(.PRESCALE(PRE), .DEBOUNCE_CYCLES(8)) dut (
        .sys_clk_in   (sys_clk_in),
        .reset_n_in   (reset_n_in),
        .xtal_clk_in  (xtal_clk),
        .restart_n_in (restart_w),
        .scl_clk_in   (scl),
        .sda_in       (sda_w),
        .sda_out      (sda_out),
        .sda_oe_out   (sda_oe),
        .alarm_out    (alarm)
    );

    wat_i2c_host host (.scl_out(scl), .sda_low_out(host_low), .sda_in(sda_w));

    // ----------------------------------------------------------------
    // Crystal stand-in, hang guard, data line watch
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in) begin
        xc <= (xc == XH - 1) ? 0 : xc + 1;
        if (xc == XH - 1) xtal_clk <= ~xtal_clk;
        cyc <= cyc + 1;
        if (sda_oe === 1'b1) check(sda_out, 1'b0);
        if (cyc == 60000) begin
            fails++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : cycles

    function automatic int edges_for(input logic [23:0] cmp);
        return cmp * PRE;
    endfunction : edges_for

    // Alarm must rise inside a window one crystal period plus 40 cycles wide
    task automatic expect_alarm(input int e);
        cycles((e - 1) * 2 * XH - 20);
        check(alarm, 1'b0);
        cycles(2 * XH + 40);
        check(alarm, 1'b1);
    endtask : expect_alarm

    task automatic write_cmp(input logic [7:0] ab, input logic [23:0] d,
                             input int n, input logic [3:0] exp_acks);
        host.write_frame({ab, d}, n, acks);
        check(acks, exp_acks);
        // Back onto a rising edge before the next pin change
        cycles(1);
    endtask : write_cmp

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        // Falling edge from unknown resets the link side as well
        reset_n_in <= 1'b0;
        c1 = 24'(1 + ($unsigned($random(seed)) % 3));
        cycles(3);
        reset_n_in <= 1'b1;
        cycles(2);
        check(alarm, 1'b0);
        check(sda_oe, 1'b0);
        write_cmp({SLV_ADDR, 1'b0}, c1, 4, 4'h0);
        expect_alarm(edges_for(c1));
        cycles(800);
        check(alarm, 1'b1);
        repeat (4) begin
            rst_en  <= 1'b1;
            rst_val <= 1'b0;
            cycles(3);
            rst_val <= 1'b1;
            cycles(3);
        end
        cycles(20);
        check(alarm, 1'b1);
        // Refused frames leave the compare alone
        write_cmp({SLV_ADDR ^ 7'h01, 1'b0}, 24'($random(seed)), 4, 4'hf);
        write_cmp({SLV_ADDR, 1'b1}, 24'($random(seed)), 4, 4'hf);
        write_cmp({SLV_ADDR, 1'b0}, 24'($random(seed)), 3, 4'h8);
        rst_val <= 1'b0;
        cycles(20);
        check(alarm, 1'b1);
        rst_val <= 1'b1;
        cycles(14);
        check(alarm, 1'b0);
        expect_alarm(edges_for(c1));
        // Store while held, then rewrite in mid-count
        rst_val <= 1'b0;
        cycles(20);
        write_cmp({SLV_ADDR, 1'b0}, 24'h000002, 4, 4'h0);
        rst_val <= 1'b1;
        cycles(14 + 2 * XH);
        write_cmp({SLV_ADDR, 1'b0}, 24'h000002, 4, 4'h0);
        expect_alarm(edges_for(24'h000002));
        cycles(10);
        complete_run();
    end
endmodule : test_wakeup_alarm_timer
